// >>> pkg/mask_div_pkg.sv
package mask_div_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_MASK_MID  = 8'h44;
    localparam logic [7:0] IDX_MASK_HIGH = 8'h45;
    localparam logic [7:0] IDX_DIV_LOW   = 8'h46;
    localparam logic [7:0] IDX_DIV_HIGH  = 8'h47;
    localparam logic [7:0] IDX_STAT_MID  = 8'h60;
    localparam logic [7:0] IDX_STAT_HIGH = 8'h61;

    // Bit positions inside the mid and high bytes
    localparam int BIT_OP_MODE  = 7;
    localparam int BIT_MAIN_REF = 6;
    localparam int BIT_THIRD    = 0;
    localparam int BIT_FRAME    = 7;

    // Event vector order used by the sticky status bank
    localparam int EV_OP_MODE  = 0;
    localparam int EV_MAIN_REF = 1;
    localparam int EV_THIRD    = 2;
    localparam int EV_FRAME    = 3;
    localparam int EV_COUNT    = 4;

    // Reset values
    localparam logic [7:0] MASK_MID_RST  = 8'h00;
    localparam logic [7:0] MASK_HIGH_RST = 8'h00;
    localparam logic [7:0] DIV_LOW_RST   = 8'hFF;
    localparam logic [7:0] DIV_HIGH_RST  = 8'h3F;

    // Bits that hold state; all others read as zero
    localparam logic [7:0] MASK_MID_WMASK  = 8'hC1;
    localparam logic [7:0] MASK_HIGH_WMASK = 8'h80;
    localparam logic [7:0] DIV_LOW_WMASK   = 8'hFF;
    localparam logic [7:0] DIV_HIGH_WMASK  = 8'h3F;

    localparam int DIVN_W = 14;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// >>> core/sticky_status.sv
`timescale 1ns/100ps
module sticky_status #(
    parameter int N = 4
) (
    input  wire logic         clk_sys,
    input  wire logic         rst_n_sync,
    input  wire logic [N-1:0] event_in,
    input  wire logic [N-1:0] clear_in,
    output logic      [N-1:0] status
);
    logic [N-1:0] status_reg;
    logic [N-1:0] status_next;

    genvar gi;
    generate
        for (gi = 0; gi < N; gi++) begin : g_bit
            // A new event in the clearing cycle keeps the bit set
            always_comb begin
                status_next[gi] = event_in[gi] | (status_reg[gi] & ~clear_in[gi]);
            end
        end
    endgenerate

    always_ff @(posedge clk_sys or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            status_reg <= '0;
        end else begin
            status_reg <= status_next;
        end
    end

    assign status = status_reg;
endmodule

// >>> core/axil_slave.sv
`timescale 1ns/100ps
module axil_slave #(
    parameter int ADDR_W = 10
) (
    input  wire logic              clk_sys,
    input  wire logic              rst_n_sync,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    output logic                   wr_en,
    output logic [7:0]             wr_index,
    output logic [31:0]            wr_data,
    output logic [3:0]             wr_strb,
    input  wire logic              wr_err,
    output logic [7:0]             rd_index,
    input  wire logic [31:0]       rd_data,
    input  wire logic              rd_err
);
    logic              aw_full_reg, aw_full_next;
    logic              w_full_reg, w_full_next;
    logic [ADDR_W-1:0] awaddr_reg, awaddr_next;
    logic [31:0]       wdata_reg, wdata_next;
    logic [3:0]        wstrb_reg, wstrb_next;
    logic              bvalid_reg, bvalid_next;
    logic [1:0]        bresp_reg, bresp_next;
    logic              rvalid_reg, rvalid_next;
    logic [31:0]       rdata_reg, rdata_next;
    logic [1:0]        rresp_reg, rresp_next;
    logic              awready_reg, wready_reg, arready_reg;
    logic              rd_take;

    localparam logic [1:0] RESP_SLVERR_L = 2'h2;

    always_comb begin
        aw_full_next = aw_full_reg;
        w_full_next  = w_full_reg;
        awaddr_next  = awaddr_reg;
        wdata_next   = wdata_reg;
        wstrb_next   = wstrb_reg;
        bvalid_next  = bvalid_reg;
        bresp_next   = bresp_reg;
        rvalid_next  = rvalid_reg;
        rdata_next   = rdata_reg;
        rresp_next   = rresp_reg;
        wr_en        = aw_full_reg && w_full_reg && !bvalid_reg;
        rd_take      = s_axi_arvalid && arready_reg;
        if (s_axi_awvalid && awready_reg) begin
            aw_full_next = 1'b1;
            awaddr_next  = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_reg) begin
            w_full_next = 1'b1;
            wdata_next  = s_axi_wdata;
            wstrb_next  = s_axi_wstrb;
        end
        if (bvalid_reg && s_axi_bready) begin
            bvalid_next = 1'b0;
        end
        if (wr_en) begin
            aw_full_next = 1'b0;
            w_full_next  = 1'b0;
            bvalid_next  = 1'b1;
            bresp_next   = wr_err ? RESP_SLVERR_L : 2'h0;
        end
        if (rvalid_reg && s_axi_rready) begin
            rvalid_next = 1'b0;
        end
        if (rd_take) begin
            rvalid_next = 1'b1;
            rdata_next  = rd_err ? 32'h0000_0000 : rd_data;
            rresp_next  = rd_err ? RESP_SLVERR_L : 2'h0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            aw_full_reg <= 1'b0;
            w_full_reg  <= 1'b0;
            awaddr_reg  <= '0;
            wdata_reg   <= 32'h0000_0000;
            wstrb_reg   <= 4'h0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= 2'h0;
            rvalid_reg  <= 1'b0;
            rdata_reg   <= 32'h0000_0000;
            rresp_reg   <= 2'h0;
            awready_reg <= 1'b0;
            wready_reg  <= 1'b0;
            arready_reg <= 1'b0;
        end else begin
            aw_full_reg <= aw_full_next;
            w_full_reg  <= w_full_next;
            awaddr_reg  <= awaddr_next;
            wdata_reg   <= wdata_next;
            wstrb_reg   <= wstrb_next;
            bvalid_reg  <= bvalid_next;
            bresp_reg   <= bresp_next;
            rvalid_reg  <= rvalid_next;
            rdata_reg   <= rdata_next;
            rresp_reg   <= rresp_next;
            awready_reg <= !aw_full_next;
            wready_reg  <= !w_full_next;
            arready_reg <= !rvalid_next;
        end
    end

    assign wr_index      = awaddr_reg[9:2];
    assign wr_data       = wdata_reg;
    assign wr_strb       = wstrb_reg;
    assign rd_index      = s_axi_araddr[9:2];
    assign s_axi_awready = awready_reg;
    assign s_axi_wready  = wready_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;
endmodule

// >>> core/interrupt_mask_and_divider_regs.sv
`timescale 1ns/100ps
module interrupt_mask_and_divider_regs
    import mask_div_pkg::*;
#(
    parameter int ADDR_W = 10
) (
    input  wire logic                          clk_sys,
    input  wire logic                          rst_n,
    input  wire logic [ADDR_W-1:0]             s_axi_awaddr,
    input  wire logic                          s_axi_awvalid,
    output logic                               s_axi_awready,
    input  wire logic [31:0]                   s_axi_wdata,
    input  wire logic [3:0]                    s_axi_wstrb,
    input  wire logic                          s_axi_wvalid,
    output logic                               s_axi_wready,
    output logic [1:0]                         s_axi_bresp,
    output logic                               s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    input  wire logic [ADDR_W-1:0]             s_axi_araddr,
    input  wire logic                          s_axi_arvalid,
    output logic                               s_axi_arready,
    output logic [31:0]                        s_axi_rdata,
    output logic [1:0]                         s_axi_rresp,
    output logic                               s_axi_rvalid,
    input  wire logic                          s_axi_rready,
    input  wire logic                          op_mode_change,
    input  wire logic                          main_ref_failed,
    input  wire logic                          third_clock_input,
    input  wire logic                          frame_pulse_input_alarm,
    output logic [mask_div_pkg::DIVN_W-1:0]    divn_value,
    output logic                               irq
);
    import mask_div_pkg::*;

    // Reset release through two flops; assertion is still immediate
    logic rst_meta_reg;
    logic rst_n_sync;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_reg <= 1'b0;
            rst_n_sync   <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_sync   <= rst_meta_reg;
        end
    end

    logic        wr_en;
    logic [7:0]  wr_index;
    logic [31:0] wr_data;
    logic [3:0]  wr_strb;
    logic        wr_err;
    logic [7:0]  rd_index;
    logic [31:0] rd_data;
    logic        rd_err;

    axil_slave #(
        .ADDR_W (ADDR_W)
    ) u_bus (
        .clk_sys       (clk_sys),
        .rst_n_sync    (rst_n_sync),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .wr_en         (wr_en),
        .wr_index      (wr_index),
        .wr_data       (wr_data),
        .wr_strb       (wr_strb),
        .wr_err        (wr_err),
        .rd_index      (rd_index),
        .rd_data       (rd_data),
        .rd_err        (rd_err)
    );

    logic [7:0] mask_mid_reg, mask_mid_next;
    logic [7:0] mask_high_reg, mask_high_next;
    logic [7:0] div_low_reg, div_low_next;
    logic [7:0] div_high_reg, div_high_next;
    logic       irq_reg, irq_next;

    logic [EV_COUNT-1:0] ev_vec;
    logic [EV_COUNT-1:0] clr_vec;
    logic [EV_COUNT-1:0] stat_vec;
    logic [EV_COUNT-1:0] mask_vec;
    logic [7:0]          stat_mid;
    logic [7:0]          stat_high;
    logic                wr_low;

    assign ev_vec[EV_OP_MODE]  = op_mode_change;
    assign ev_vec[EV_MAIN_REF] = main_ref_failed;
    assign ev_vec[EV_THIRD]    = third_clock_input;
    assign ev_vec[EV_FRAME]    = frame_pulse_input_alarm;

    sticky_status #(
        .N (EV_COUNT)
    ) u_status (
        .clk_sys    (clk_sys),
        .rst_n_sync (rst_n_sync),
        .event_in   (ev_vec),
        .clear_in   (clr_vec),
        .status     (stat_vec)
    );

    // Status bytes share the layout of the mask bytes
    always_comb begin
        stat_mid               = 8'h00;
        stat_high              = 8'h00;
        stat_mid[BIT_OP_MODE]  = stat_vec[EV_OP_MODE];
        stat_mid[BIT_MAIN_REF] = stat_vec[EV_MAIN_REF];
        stat_mid[BIT_THIRD]    = stat_vec[EV_THIRD];
        stat_high[BIT_FRAME]   = stat_vec[EV_FRAME];
    end

    always_comb begin
        mask_vec[EV_OP_MODE]  = mask_mid_reg[BIT_OP_MODE];
        mask_vec[EV_MAIN_REF] = mask_mid_reg[BIT_MAIN_REF];
        mask_vec[EV_THIRD]    = mask_mid_reg[BIT_THIRD];
        mask_vec[EV_FRAME]    = mask_high_reg[BIT_FRAME];
    end

    // Only byte lane 0 carries register data; other lanes are ignored
    assign wr_low = wr_en && wr_strb[0];

    always_comb begin
        clr_vec = '0;
        if (wr_low && wr_index == IDX_STAT_MID) begin
            clr_vec[EV_OP_MODE]  = wr_data[BIT_OP_MODE];
            clr_vec[EV_MAIN_REF] = wr_data[BIT_MAIN_REF];
            clr_vec[EV_THIRD]    = wr_data[BIT_THIRD];
        end
        if (wr_low && wr_index == IDX_STAT_HIGH) begin
            clr_vec[EV_FRAME] = wr_data[BIT_FRAME];
        end
    end

    always_comb begin
        mask_mid_next  = mask_mid_reg;
        mask_high_next = mask_high_reg;
        div_low_next   = div_low_reg;
        div_high_next  = div_high_reg;
        if (wr_low) begin
            unique case (wr_index)
                IDX_MASK_MID:  mask_mid_next  = wr_data[7:0] & MASK_MID_WMASK;
                IDX_MASK_HIGH: mask_high_next = wr_data[7:0] & MASK_HIGH_WMASK;
                IDX_DIV_LOW:   div_low_next   = wr_data[7:0] & DIV_LOW_WMASK;
                IDX_DIV_HIGH:  div_high_next  = wr_data[7:0] & DIV_HIGH_WMASK;
                default: ;
            endcase
        end
    end

    always_comb begin
        unique case (wr_index)
            IDX_MASK_MID, IDX_MASK_HIGH, IDX_DIV_LOW, IDX_DIV_HIGH,
            IDX_STAT_MID, IDX_STAT_HIGH: wr_err = 1'b0;
            default:                     wr_err = 1'b1;
        endcase
    end

    always_comb begin
        rd_err  = 1'b0;
        rd_data = 32'h0000_0000;
        unique case (rd_index)
            IDX_MASK_MID:  rd_data[7:0] = mask_mid_reg;
            IDX_MASK_HIGH: rd_data[7:0] = mask_high_reg;
            IDX_DIV_LOW:   rd_data[7:0] = div_low_reg;
            IDX_DIV_HIGH:  rd_data[7:0] = div_high_reg;
            IDX_STAT_MID:  rd_data[7:0] = stat_mid;
            IDX_STAT_HIGH: rd_data[7:0] = stat_high;
            default:       rd_err       = 1'b1;
        endcase
    end

    // Registered from the held status so the pin is glitch free
    always_comb begin
        irq_next = |(stat_vec & mask_vec);
    end

    always_ff @(posedge clk_sys or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            mask_mid_reg  <= MASK_MID_RST;
            mask_high_reg <= MASK_HIGH_RST;
            div_low_reg   <= DIV_LOW_RST;
            div_high_reg  <= DIV_HIGH_RST;
            irq_reg       <= 1'b0;
        end else begin
            mask_mid_reg  <= mask_mid_next;
            mask_high_reg <= mask_high_next;
            div_low_reg   <= div_low_next;
            div_high_reg  <= div_high_next;
            irq_reg       <= irq_next;
        end
    end

    assign divn_value = {div_high_reg[5:0], div_low_reg};
    assign irq        = irq_reg;

    default clocking cb_main @(posedge clk_sys); endclocking
    default disable iff (!rst_n_sync);

    property p_op_mode_gate;
        (stat_vec[EV_OP_MODE] && mask_mid_reg[BIT_OP_MODE]) |=> irq;
    endproperty
    a_op_mode_gate: assert property (p_op_mode_gate) else $error("op mode irq not raised");

    property p_main_ref_gate;
        (stat_vec[EV_MAIN_REF] && mask_mid_reg[BIT_MAIN_REF]) |=> irq;
    endproperty
    a_main_ref_gate: assert property (p_main_ref_gate) else $error("main ref irq not raised");

    property p_third_gate;
        (stat_vec[EV_THIRD] && mask_mid_reg[BIT_THIRD]) |=> irq;
    endproperty
    a_third_gate: assert property (p_third_gate) else $error("third input irq not raised");

    property p_frame_gate;
        (stat_vec[EV_FRAME] && mask_high_reg[BIT_FRAME]) |=> irq;
    endproperty
    a_frame_gate: assert property (p_frame_gate) else $error("frame alarm irq not raised");

    property p_high_unused;
        mask_high_reg[6:0] == 7'h00;
    endproperty
    a_high_unused: assert property (p_high_unused) else $error("unused high mask bits set");

    property p_blocked;
        (mask_mid_reg == 8'h00 && mask_high_reg == 8'h00) [*2] |-> !irq;
    endproperty
    a_blocked: assert property (p_blocked) else $error("irq with all masks clear");

    property p_reset_masks;
        $rose(rst_n_sync) |-> (mask_mid_reg == 8'h00 && mask_high_reg == 8'h00 && !irq);
    endproperty
    a_reset_masks: assert property (p_reset_masks) else $error("masks not zero after reset");

    property p_reset_div;
        $rose(rst_n_sync) |-> divn_value == 14'h3FFF;
    endproperty
    a_reset_div: assert property (p_reset_div) else $error("divider reset value wrong");

    property p_div_write;
        (wr_low && wr_index == IDX_DIV_HIGH) |=> divn_value[13:8] == $past(wr_data[5:0]);
    endproperty
    a_div_write: assert property (p_div_write) else $error("divider high write lost");

    property p_div_upper_zero;
        div_high_reg[7:6] == 2'h0;
    endproperty
    a_div_upper_zero: assert property (p_div_upper_zero) else $error("divider upper bits set");

    property p_mask_mid_write;
        (wr_low && wr_index == IDX_MASK_MID) |=> mask_mid_reg == ($past(wr_data[7:0]) & MASK_MID_WMASK);
    endproperty
    a_mask_mid_write: assert property (p_mask_mid_write) else $error("mid mask write lost");

    property p_mask_high_write;
        (wr_low && wr_index == IDX_MASK_HIGH) |=> mask_high_reg[7] == $past(wr_data[7]);
    endproperty
    a_mask_high_write: assert property (p_mask_high_write) else $error("high mask write lost");

    property p_div_low_write;
        (wr_low && wr_index == IDX_DIV_LOW) |=> divn_value[7:0] == $past(wr_data[7:0]);
    endproperty
    a_div_low_write: assert property (p_div_low_write) else $error("divider low write lost");

    // When every source is masked off or idle the pin must be low a cycle later
    property p_irq_blocked;
        ((stat_vec & mask_vec) == 4'h0) |=> !irq;
    endproperty
    a_irq_blocked: assert property (p_irq_blocked) else $error("irq without unmasked status");

    property p_set_wins;
        (ev_vec[EV_THIRD] && clr_vec[EV_THIRD]) |=> stat_vec[EV_THIRD];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("event lost in clearing cycle");

    c_masked_irq: cover property (irq_reg && mask_mid_reg[BIT_OP_MODE]);
    c_clear_race: cover property (clr_vec[EV_THIRD] && ev_vec[EV_THIRD]);
    c_div_write:  cover property (wr_low && wr_index == IDX_DIV_LOW);
    c_frame_irq:  cover property (irq_reg && mask_high_reg[BIT_FRAME]);
    c_third_irq:  cover property (irq_reg && mask_mid_reg[BIT_THIRD]);

endmodule

// >>> bench/tb.sv
`timescale 1ns/100ps
module tb;
    import mask_div_pkg::*;

    logic                       clk_sys;
    logic                       rst_n;
    logic [9:0]                 awaddr;
    logic                       awvalid;
    logic                       awready;
    logic [31:0]                wdata;
    logic [3:0]                 wstrb;
    logic                       wvalid;
    logic                       wready;
    logic [1:0]                 bresp;
    logic                       bvalid;
    logic                       bready;
    logic [9:0]                 araddr;
    logic                       arvalid;
    logic                       arready;
    logic [31:0]                rdata;
    logic [1:0]                 rresp;
    logic                       rvalid;
    logic                       rready;
    logic [3:0]                 ev;
    logic [DIVN_W-1:0]          divn_value;
    logic                       irq;
    int                         n_fail;
    int                         n_compared;
    logic [1:0]                 resp;
    logic [31:0]                val;
    logic [3:0]                 strb;
    logic [7:0]                 idx_m [4];
    logic [7:0]                 idx_s [4];
    int                         bpos  [4];

    interrupt_mask_and_divider_regs #(.ADDR_W(10)) uut (
        .clk_sys                 (clk_sys),
        .rst_n                   (rst_n),
        .s_axi_awaddr            (awaddr),
        .s_axi_awvalid           (awvalid),
        .s_axi_awready           (awready),
        .s_axi_wdata             (wdata),
        .s_axi_wstrb             (wstrb),
        .s_axi_wvalid            (wvalid),
        .s_axi_wready            (wready),
        .s_axi_bresp             (bresp),
        .s_axi_bvalid            (bvalid),
        .s_axi_bready            (bready),
        .s_axi_araddr            (araddr),
        .s_axi_arvalid           (arvalid),
        .s_axi_arready           (arready),
        .s_axi_rdata             (rdata),
        .s_axi_rresp             (rresp),
        .s_axi_rvalid            (rvalid),
        .s_axi_rready            (rready),
        .op_mode_change          (ev[0]),
        .main_ref_failed         (ev[1]),
        .third_clock_input       (ev[2]),
        .frame_pulse_input_alarm (ev[3]),
        .divn_value              (divn_value),
        .irq                     (irq)
    );

    always #10 clk_sys = ~clk_sys;

    task automatic test_done();
        if (n_fail == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // Address and data are offered together; each is dropped once taken
    task automatic axi_write(input logic [7:0] idx, input logic [7:0] data, output logic [1:0] rsp);
        int   k;
        logic aw_done;
        logic w_done;
        aw_done = 1'h0;
        w_done  = 1'h0;
        @(posedge clk_sys);
        awaddr  <= {idx, 2'h0};
        awvalid <= 1'h1;
        wdata   <= {24'h000000, data};
        wstrb   <= strb;
        wvalid  <= 1'h1;
        bready  <= 1'h1;
        for (k = 0; k < 50; k++) begin
            @(posedge clk_sys);
            if (!aw_done && awready) begin
                aw_done = 1'h1;
                awvalid <= 1'h0;
            end
            if (!w_done && wready) begin
                w_done = 1'h1;
                wvalid <= 1'h0;
            end
            if (bvalid) begin
                rsp = bresp;
                bready <= 1'h0;
                break;
            end
        end
        if (k == 50) begin
            n_fail++;
            test_done();
        end
    endtask

    task automatic axi_read(input logic [7:0] idx, output logic [31:0] data, output logic [1:0] rsp);
        int   k;
        logic ar_done;
        ar_done = 1'h0;
        @(posedge clk_sys);
        araddr  <= {idx, 2'h0};
        arvalid <= 1'h1;
        rready  <= 1'h1;
        for (k = 0; k < 50; k++) begin
            @(posedge clk_sys);
            if (!ar_done && arready) begin
                ar_done = 1'h1;
                arvalid <= 1'h0;
            end
            if (rvalid) begin
                data = rdata;
                rsp  = rresp;
                rready <= 1'h0;
                break;
            end
        end
        if (k == 50) begin
            n_fail++;
            test_done();
        end
    endtask

    task automatic reg_check(input logic [7:0] idx, input logic [7:0] exp);
        axi_read(idx, val, resp);
        chk(val, {24'h000000, exp});
        chk({30'h0, resp}, {30'h0, RESP_OKAY});
    endtask

    task automatic reg_write(input logic [7:0] idx, input logic [7:0] data);
        axi_write(idx, data, resp);
        chk({30'h0, resp}, {30'h0, RESP_OKAY});
    endtask

    initial begin
        clk_sys = 1'h0;
        rst_n   = 1'h0;
        awaddr  = 10'h000;
        awvalid = 1'h0;
        wdata   = 32'h00000000;
        wstrb   = 4'h0;
        wvalid  = 1'h0;
        bready  = 1'h0;
        araddr  = 10'h000;
        arvalid = 1'h0;
        rready  = 1'h0;
        ev      = 4'h0;
        strb    = 4'hF;
        n_fail  = 0;
        n_compared = 0;
        idx_m = '{IDX_MASK_MID, IDX_MASK_MID, IDX_MASK_MID, IDX_MASK_HIGH};
        idx_s = '{IDX_STAT_MID, IDX_STAT_MID, IDX_STAT_MID, IDX_STAT_HIGH};
        bpos  = '{BIT_OP_MODE, BIT_MAIN_REF, BIT_THIRD, BIT_FRAME};
        tick(16);
        rst_n <= 1'h1;
        tick(4);

        reg_check(IDX_MASK_MID, 8'h00);
        reg_check(IDX_MASK_HIGH, 8'h00);
        reg_check(IDX_DIV_LOW, 8'hFF);
        reg_check(IDX_DIV_HIGH, 8'h3F);
        chk({18'h00000, divn_value}, 32'h00003FFF);

        // Unmapped place answers with an error and reads zero
        axi_read(8'h50, val, resp);
        chk(val, 32'h00000000);
        chk({30'h0, resp}, {30'h0, RESP_SLVERR});
        axi_write(8'h50, 8'hFF, resp);
        chk({30'h0, resp}, {30'h0, RESP_SLVERR});

        // Only the documented mask bits hold state
        reg_write(IDX_MASK_MID, 8'hFF);
        reg_check(IDX_MASK_MID, 8'hC1);
        reg_write(IDX_MASK_HIGH, 8'hFF);
        reg_check(IDX_MASK_HIGH, 8'h80);

        // Divider bytes take effect one at a time; upper bits read zero
        reg_write(IDX_DIV_LOW, 8'h34);
        tick(2);
        chk({18'h00000, divn_value}, 32'h00003F34);
        reg_write(IDX_DIV_HIGH, 8'hD2);
        tick(2);
        chk({18'h00000, divn_value}, 32'h00001234);
        reg_check(IDX_DIV_HIGH, 8'h12);

        // A write without byte lane 0 changes nothing
        strb = 4'hE;
        reg_write(IDX_DIV_LOW, 8'h00);
        strb = 4'hF;
        reg_check(IDX_DIV_LOW, 8'h34);

        // Each source: blocked while masked, passes once unmasked
        for (int i = 0; i < 4; i++) begin
            reg_write(IDX_MASK_MID, 8'h00);
            reg_write(IDX_MASK_HIGH, 8'h00);
            @(posedge clk_sys);
            ev <= 4'h1 << i;
            @(posedge clk_sys);
            ev <= 4'h0;
            tick(4);
            chk({31'h0, irq}, 32'h00000000);
            reg_check(idx_s[i], 8'h01 << bpos[i]);
            reg_write(idx_m[i], 8'h01 << bpos[i]);
            tick(3);
            chk({31'h0, irq}, 32'h00000001);
            reg_write(idx_m[i], 8'h00);
            tick(3);
            chk({31'h0, irq}, 32'h00000000);
            reg_write(idx_m[i], 8'h01 << bpos[i]);
            reg_write(idx_s[i], 8'h01 << bpos[i]);
            tick(3);
            chk({31'h0, irq}, 32'h00000000);
            reg_check(idx_s[i], 8'h00);
        end

        // Event held across its own clear: the set wins
        reg_write(IDX_MASK_MID, 8'h01);
        ev <= 4'h4;
        reg_write(IDX_STAT_MID, 8'h01);
        ev <= 4'h0;
        reg_check(IDX_STAT_MID, 8'h01);
        chk({31'h0, irq}, 32'h00000001);
        reg_write(IDX_STAT_MID, 8'h01);
        tick(3);
        chk({31'h0, irq}, 32'h00000000);

        // A second reset restores the defaults
        @(posedge clk_sys);
        rst_n <= 1'h0;
        tick(4);
        rst_n <= 1'h1;
        tick(4);
        reg_check(IDX_MASK_MID, 8'h00);
        reg_check(IDX_MASK_HIGH, 8'h00);
        chk({18'h00000, divn_value}, 32'h00003FFF);
        test_done();
    end
endmodule
